// *** logic/pts_event_filter.sv ***
// Stability filter for one event input, counted in sampling ticks
`default_nettype none
module pts_event_filter (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  input  wire logic       sampleTick,
  input  wire logic [4:0] window,
  input  wire logic       din,
  output var  logic       dout
);
  import pts_pkg::*;

  logic [4:0] stableCnt_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stableCnt_r <= 5'h00;
      dout        <= 1'b0;
    end else if (clkEn && sampleTick) begin
      if (din == dout) begin
        stableCnt_r <= 5'h00;
      end else if (stableCnt_r + 5'h01 >= window) begin
        dout        <= din;
        stableCnt_r <= 5'h00;
      end else begin
        stableCnt_r <= stableCnt_r + 5'h01;
      end
    end
  end

endmodule : pts_event_filter
`default_nettype wire

// *** logic/pts_pkg.sv ***
// Package: register map, reset values, field layout and types of the block
`default_nettype none
package pts_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_SAMPLE_CTRL  = 16'hf4ab;
  localparam logic [15:0] IDX_DIV_CTRL     = 16'hf4ac;
  localparam logic [15:0] IDX_PERIOD_LOW   = 16'hf4b0;
  localparam logic [15:0] IDX_PERIOD_HIGH  = 16'hf4b1;
  localparam logic [15:0] IDX_DUTY_LOW     = 16'hf4b2;
  localparam logic [15:0] IDX_DUTY_HIGH    = 16'hf4b3;
  localparam logic [15:0] IDX_COUNT_LOW    = 16'hf4b4;
  localparam logic [15:0] IDX_COUNT_HIGH   = 16'hf4b5;
  localparam logic [15:0] IDX_MODE_CTRL    = 16'hf4c0;
  localparam logic [15:0] IDX_STATUS       = 16'hf4c1;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_SAMPLE_CTRL  = 8'h00;
  localparam logic [7:0]  RST_DIV_CTRL     = 8'h00;
  localparam logic [7:0]  RST_PERIOD_BYTE  = 8'hff;
  localparam logic [7:0]  RST_DUTY_BYTE    = 8'h00;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
  localparam logic [7:0]  RST_MODE_CTRL    = 8'h00;
  localparam logic [7:0]  SAMPLE_CTRL_MASK = 8'h33;
  localparam logic [7:0]  DIV_CTRL_MASK    = 8'h07;
  localparam int          EVT1_SEL_POS     = 4;
  localparam int          EVT0_SEL_POS     = 0;
  localparam logic [15:0] PERIOD_ZERO_SUB  = 16'h0001;

  // ------------------------------------------------------------
  // Timing constants
  // ------------------------------------------------------------
  localparam logic [4:0]  WIN_BASE         = 5'h02;
  localparam logic [2:0]  DIV_CODE_ILLEGAL = 3'h7;

  typedef enum logic [1:0] {
    SRC_LOW_SPEED = 2'b00,
    SRC_OSC       = 2'b01,
    SRC_UNUSED    = 2'b10,
    SRC_EXTERNAL  = 2'b11
  } pts_clk_src_t;

  // Own mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic         ch5Run;
    logic         sysClkHigh;
    pts_clk_src_t ch5Src;
    pts_clk_src_t ch4Src;
    logic         deadTimeEnable;
    logic         pairCoupling;
  } pts_mode_t;

  // Outputs toward the pwm channel logic
  typedef struct packed {
    logic        ch4Tick;
    logic        ch5Tick;
    logic [1:0]  ch4Event;
    logic [1:0]  ch5Event;
    logic        ch5Out;
    logic [15:0] deadTime;
  } pts_pwm_out_t;

endpackage : pts_pkg
`default_nettype wire

// *** logic/pts_pwm_regs.sv ***
// Event sampling, clock divider and channel five registers behind APB
//
// The implementer's own choice: the APB register port.
`default_nettype none
module pts_pwm_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 lowSpeedClkPin,
  input  wire logic                 oscClkPin,
  input  wire logic                 extClkPin,
  input  wire logic [1:0]           eventPin,
  output var  pts_pkg::pts_pwm_out_t pwmOut
);
  import pts_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic srcTick(input pts_clk_src_t sel,
                                   input logic ls, input logic osc,
                                   input logic ext);
    unique case (sel)
      SRC_LOW_SPEED: srcTick = ls;
      SRC_OSC:       srcTick = osc;
      SRC_EXTERNAL:  srcTick = ext;
      default:       srcTick = 1'b0;
    endcase
  endfunction : srcTick

  function automatic logic [4:0] sampleWindow(input logic [1:0] code,
                                              input logic oscMode);
    sampleWindow = oscMode ? 5'(WIN_BASE << code) : WIN_BASE;
  endfunction : sampleWindow

  function automatic logic [5:0] divMask(input logic [2:0] code);
    divMask = (code == DIV_CODE_ILLEGAL) ? 6'h00
                                         : 6'((7'h01 << code) - 7'h01);
  endfunction : divMask

  function automatic logic hitIdx(input logic [31:0] addr,
                                  input logic [15:0] idx);
    hitIdx = (addr == {14'h0000, idx, 2'b00});
  endfunction : hitIdx

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [4:0] pinSync1_r;
  logic [4:0] pinSync2_r;
  logic [2:0] clkPrev_r;
  logic       lsTick;
  logic       oscTick;
  logic       extTick;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinSync1_r <= 5'h00;
      pinSync2_r <= 5'h00;
      clkPrev_r  <= 3'h0;
    end else if (clkEn) begin
      pinSync1_r <= {eventPin, extClkPin, oscClkPin, lowSpeedClkPin};
      pinSync2_r <= pinSync1_r;
      clkPrev_r  <= pinSync2_r[2:0];
    end
  end

  assign lsTick  = clkEn & pinSync2_r[0] & ~clkPrev_r[0];
  assign oscTick = clkEn & pinSync2_r[1] & ~clkPrev_r[1];
  assign extTick = clkEn & pinSync2_r[2] & ~clkPrev_r[2];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  sampleCtrl_r;
  logic [7:0]  divCtrl_r;
  logic [7:0]  periodLow_r;
  logic [7:0]  periodHigh_r;
  logic [15:0] periodBuf_r;
  logic [15:0] duty_r;
  logic [15:0] count_r;
  logic [7:0]  countHighLatch_r;
  pts_mode_t   mode_r;
  logic [5:0]  prescale_r;
  logic        ch5Out_r;
  logic [31:0] prdata_nxt;
  logic        addrOk;
  logic        setupPh;
  logic        wrAcc;
  logic        rdAcc;
  logic        countReadable;
  logic [15:0] periodWr;

  assign setupPh = psel & ~penable;
  assign wrAcc   = clkEn & psel & penable & pwrite;
  assign rdAcc   = clkEn & setupPh & ~pwrite;
  assign pready  = 1'b1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sampleCtrl_r <= RST_SAMPLE_CTRL;
      divCtrl_r    <= RST_DIV_CTRL;
      mode_r       <= pts_mode_t'(RST_MODE_CTRL);
    end else if (wrAcc) begin
      if (hitIdx(paddr, IDX_SAMPLE_CTRL)) begin
        sampleCtrl_r <= pwdata[7:0] & SAMPLE_CTRL_MASK;
      end
      if (hitIdx(paddr, IDX_DIV_CTRL)) begin
        divCtrl_r <= pwdata[7:0] & DIV_CTRL_MASK;
      end
      if (hitIdx(paddr, IDX_MODE_CTRL)) begin
        mode_r <= pts_mode_t'(pwdata[7:0]);
      end
    end
  end

  // Period bytes and the buffer the counter compares against
  always_comb begin
    periodWr = {periodHigh_r, periodLow_r};
    if (hitIdx(paddr, IDX_PERIOD_LOW)) begin
      periodWr = {periodHigh_r, pwdata[7:0]};
    end else if (hitIdx(paddr, IDX_PERIOD_HIGH)) begin
      periodWr = {pwdata[7:0], periodLow_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      periodLow_r  <= RST_PERIOD_BYTE;
      periodHigh_r <= RST_PERIOD_BYTE;
      periodBuf_r  <= {RST_PERIOD_BYTE, RST_PERIOD_BYTE};
    end else if (wrAcc && (hitIdx(paddr, IDX_PERIOD_LOW) ||
                           hitIdx(paddr, IDX_PERIOD_HIGH))) begin
      periodLow_r  <= periodWr[7:0];
      periodHigh_r <= periodWr[15:8];
      // Byte writes pass through a transient value; each byte write loads the buffer at once
      periodBuf_r  <= (periodWr == 16'h0000) ? PERIOD_ZERO_SUB
                                             : periodWr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      duty_r <= {RST_DUTY_BYTE, RST_DUTY_BYTE};
    end else if (wrAcc) begin
      if (hitIdx(paddr, IDX_DUTY_LOW)) begin
        duty_r[7:0] <= pwdata[7:0];
      end
      if (hitIdx(paddr, IDX_DUTY_HIGH)) begin
        duty_r[15:8] <= pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Channel four divider and channel ticks
  // ------------------------------------------------------------
  logic ch4SrcTick;
  logic ch4Tick;
  logic ch5Tick;

  assign ch4SrcTick = srcTick(mode_r.ch4Src, lsTick, oscTick, extTick);
  assign ch4Tick    = ch4SrcTick &&
    ((prescale_r & divMask(divCtrl_r[2:0])) ==
     divMask(divCtrl_r[2:0]));
  assign ch5Tick    = mode_r.pairCoupling ? ch4Tick :
    srcTick(mode_r.ch5Src, lsTick, oscTick, extTick);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prescale_r <= 6'h00;
    end else if (ch4SrcTick) begin
      prescale_r <= prescale_r + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // Event input sampling
  // ------------------------------------------------------------
  logic [1:0] ch4Event;
  logic [1:0] ch5EventOwn;
  logic       ch4OscMode;
  logic       ch5OscMode;
  logic [4:0] ch4Window [2];

  assign ch4OscMode  = (mode_r.ch4Src == SRC_OSC);
  assign ch5OscMode  = (mode_r.ch5Src == SRC_OSC);
  assign ch4Window[0] = sampleWindow(sampleCtrl_r[EVT0_SEL_POS +: 2],
                                     ch4OscMode);
  assign ch4Window[1] = sampleWindow(sampleCtrl_r[EVT1_SEL_POS +: 2],
                                     ch4OscMode);

  for (genvar i = 0; i < 2; i++) begin : g_evt
    pts_event_filter u_ch4 (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .clkEn      (clkEn),
      .sampleTick (ch4OscMode ? oscTick : lsTick),
      .window     (ch4Window[i]),
      .din        (pinSync2_r[3 + i]),
      .dout       (ch4Event[i])
    );
    // Uncoupled channel five has no window setting of its own
    pts_event_filter u_ch5 (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .clkEn      (clkEn),
      .sampleTick (ch5OscMode ? oscTick : lsTick),
      .window     (WIN_BASE),
      .din        (pinSync2_r[3 + i]),
      .dout       (ch5EventOwn[i])
    );
  end

  // ------------------------------------------------------------
  // Channel five counter
  // ------------------------------------------------------------
  logic countWr;

  assign countWr = wrAcc && (hitIdx(paddr, IDX_COUNT_LOW) ||
                             hitIdx(paddr, IDX_COUNT_HIGH));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_r <= RST_COUNT;
    end else if (countWr) begin
      count_r <= RST_COUNT;
    end else if (clkEn && mode_r.ch5Run && ch5Tick) begin
      count_r <= (count_r >= periodBuf_r) ? RST_COUNT
                                          : count_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      countHighLatch_r <= RST_COUNT[15:8];
    end else if (rdAcc && hitIdx(paddr, IDX_COUNT_LOW)) begin
      // Same edge that captures the low byte, so the pair stays coherent
      countHighLatch_r <= count_r[15:8];
    end
  end

  // Duty compare is off while duty carries the dead time
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ch5Out_r <= 1'b0;
    end else if (clkEn) begin
      ch5Out_r <= ~(mode_r.pairCoupling & mode_r.deadTimeEnable) &
                  (count_r < duty_r);
    end
  end

  always_comb begin
    pwmOut          = '0;
    pwmOut.ch4Tick  = ch4Tick;
    pwmOut.ch5Tick  = ch5Tick;
    pwmOut.ch4Event = ch4Event;
    pwmOut.ch5Event = mode_r.pairCoupling ? ch4Event : ch5EventOwn;
    pwmOut.ch5Out   = ch5Out_r;
    if (mode_r.pairCoupling && mode_r.deadTimeEnable) begin
      pwmOut.deadTime = duty_r;
    end
  end

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  assign countReadable = ~mode_r.ch5Run ||
    (mode_r.ch5Src == SRC_LOW_SPEED) ||
    (mode_r.ch5Src == SRC_OSC && mode_r.sysClkHigh);

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    addrOk     = 1'b1;
    if (hitIdx(paddr, IDX_SAMPLE_CTRL)) begin
      prdata_nxt[7:0] = sampleCtrl_r;
    end else if (hitIdx(paddr, IDX_DIV_CTRL)) begin
      prdata_nxt[7:0] = divCtrl_r;
    end else if (hitIdx(paddr, IDX_PERIOD_LOW)) begin
      prdata_nxt[7:0] = periodLow_r;
    end else if (hitIdx(paddr, IDX_PERIOD_HIGH)) begin
      prdata_nxt[7:0] = periodHigh_r;
    end else if (hitIdx(paddr, IDX_DUTY_LOW)) begin
      prdata_nxt[7:0] = duty_r[7:0];
    end else if (hitIdx(paddr, IDX_DUTY_HIGH)) begin
      prdata_nxt[7:0] = duty_r[15:8];
    end else if (hitIdx(paddr, IDX_COUNT_LOW)) begin
      prdata_nxt[7:0] = countReadable ? count_r[7:0] : 8'h00;
    end else if (hitIdx(paddr, IDX_COUNT_HIGH)) begin
      prdata_nxt[7:0] = countReadable ? countHighLatch_r : 8'h00;
    end else if (hitIdx(paddr, IDX_MODE_CTRL)) begin
      prdata_nxt[7:0] = mode_r;
    end else if (hitIdx(paddr, IDX_STATUS)) begin
      prdata_nxt[7:0] = {3'b000, ch5Out_r, pwmOut.ch5Event,
                         ch4Event[1], countReadable};
    end else begin
      addrOk = 1'b0;
    end
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clkEn && setupPh) begin
      prdata  <= pwrite ? 32'h0000_0000 : prdata_nxt;
      pslverr <= ~addrOk;
    end
  end

endmodule : pts_pwm_regs
`default_nettype wire

// *** tb/pts_chk.sv ***
// Checker: port-level properties of the pwm register block
`default_nettype none
module pts_chk (
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire pts_pkg::pts_pwm_out_t pwmOut
);
  timeunit 1ns;
  timeprecision 1ns;
  import pts_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Shadow of mode and duty, seen on the bus
  // ----------------------------------------
  logic [7:0]  mode_r;
  logic [15:0] duty_r;
  logic [15:0] idx;
  logic        acc;
  logic        rdAcc;
  logic        cpl;
  logic        dt;
  logic        unread;
  assign idx = paddr[17:2];
  assign acc = psel && penable;
  assign rdAcc = acc && !pwrite;
  assign cpl = mode_r[0];
  assign dt = mode_r[1:0] == 2'b11;
  // Counter hidden while running from external source, or oscillator with slow system
  assign unread = mode_r[7] && (mode_r[5:4] == 2'b11
                  || (mode_r[5:4] == 2'b01 && !mode_r[6]));
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_r <= 8'h00;
      duty_r <= 16'h0000;
    end else if (acc && pwrite && pready) begin
      if (idx == IDX_MODE_CTRL) mode_r <= pwdata[7:0];
      if (idx == IDX_DUTY_LOW) duty_r[7:0] <= pwdata[7:0];
      if (idx == IDX_DUTY_HIGH) duty_r[15:8] <= pwdata[7:0];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_dead_duty: assert property (dt |-> pwmOut.deadTime == duty_r)
    else $error("dead time differs from duty");
  a_dead_zero: assert property (!dt |-> pwmOut.deadTime == 16'h0000)
    else $error("dead time set outside coupled dead-time mode");
  a_out_forced: assert property (dt && $past(dt) |-> !pwmOut.ch5Out)
    else $error("channel five output active in dead-time mode");
  a_tick_coupled: assert property (cpl |-> pwmOut.ch5Tick == pwmOut.ch4Tick)
    else $error("coupled channel five tick differs");
  a_event_coupled: assert property (cpl |-> pwmOut.ch5Event == pwmOut.ch4Event)
    else $error("coupled channel five events differ");
  a_rsv_sample: assert property (rdAcc && idx == IDX_SAMPLE_CTRL
    |-> (prdata & ~32'h33) == 32'h0)
    else $error("sample control reserved bits set");
  a_rsv_div: assert property (rdAcc && idx == IDX_DIV_CTRL
    |-> (prdata & ~32'h07) == 32'h0)
    else $error("divider control reserved bits set");
  a_cnt_hidden: assert property (rdAcc && idx == IDX_COUNT_LOW && unread
    |-> prdata == 32'h0)
    else $error("counter readable in a hidden combination");
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  cover property (dt && acc);
  cover property (rdAcc && unread && idx == IDX_COUNT_LOW);
  cover property (cpl && pwmOut.ch4Tick);
endmodule : pts_chk
`default_nettype wire

// *** tb/pts_pins.sv ***
// Pin model: free-running clock pins and commanded event levels
`default_nettype none
module pts_pins (
  input  wire logic       sys_clk,
  input  wire logic [1:0] evtLevel,
  output var  logic       lowSpeedClkPin,
  output var  logic       oscClkPin,
  output var  logic       extClkPin,
  output var  logic [1:0] eventPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tick_r = 8'h00;
  always @(posedge sys_clk) tick_r <= tick_r + 8'h01;
  // Oscillator every 4 cycles, low speed every 16, external every 32
  assign oscClkPin = tick_r[1];
  assign lowSpeedClkPin = tick_r[3];
  assign extClkPin = tick_r[4];
  assign eventPin = evtLevel;
endmodule : pts_pins
`default_nettype wire

// *** tb/testbench.sv ***
// Top bench: drives the register block over APB and checks its pins
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pts_pkg::*;
  logic         sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [31:0]  paddr, pwdata, prdata, rd;
  logic         err, lsPin, oscPin, extPin, clkEn;
  logic [1:0]   evtLevel, evtPin;
  pts_pwm_out_t pwmOut;
  int           fail_count, checks;
  pts_pwm_regs pts_pwm_regs_i (.sys_clk(sys_clk), .reset(reset),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lowSpeedClkPin(lsPin), .oscClkPin(oscPin),
    .extClkPin(extPin), .eventPin(evtPin), .pwmOut(pwmOut));
  pts_pins pts_pins_i (.sys_clk(sys_clk), .evtLevel(evtLevel),
    .lowSpeedClkPin(lsPin), .oscClkPin(oscPin), .extClkPin(extPin),
    .eventPin(evtPin));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string name, input logic [15:0] idx,
                       input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask : rdchk
  task automatic bit_chk(input string name, input logic b);
    check(name, {31'h0, b}, 32'h1);
  endtask : bit_chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rdchk("sample", IDX_SAMPLE_CTRL, 32'h00);
    rdchk("divider", IDX_DIV_CTRL, 32'h00);
    rdchk("per_lo", IDX_PERIOD_LOW, 32'hff);
    rdchk("per_hi", IDX_PERIOD_HIGH, 32'hff);
    rdchk("duty_lo", IDX_DUTY_LOW, 32'h00);
    rdchk("duty_hi", IDX_DUTY_HIGH, 32'h00);
    rdchk("cnt_lo", IDX_COUNT_LOW, 32'h00);
    rdchk("mode", IDX_MODE_CTRL, 32'h00);
  endtask : test_reset
  task automatic test_reserved();
    apb(1'b1, IDX_SAMPLE_CTRL, 8'hff);
    rdchk("sample_rsv", IDX_SAMPLE_CTRL, 32'h33);
    apb(1'b1, IDX_DIV_CTRL, 8'hff);
    rdchk("div_rsv", IDX_DIV_CTRL, 32'h07);
    apb(1'b0, 16'hf4ad, 8'h00);
    bit_chk("unmapped_err", err);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, IDX_DIV_CTRL, 8'h00);
  endtask : test_reserved
  task automatic test_counter();
    logic one;
    one = 1'b0;
    apb(1'b1, IDX_PERIOD_LOW, 8'h00);
    apb(1'b1, IDX_PERIOD_HIGH, 8'h00);
    rdchk("per_zero", IDX_PERIOD_HIGH, 32'h00);
    apb(1'b1, IDX_MODE_CTRL, 8'hd0);
    for (int i = 0; i < 8; i++) begin
      repeat (i) @(posedge sys_clk);
      apb(1'b0, IDX_COUNT_LOW, 8'h00);
      bit_chk("cnt_wrap", rd <= 32'h1);
      one = one | (rd == 32'h1);
    end
    bit_chk("cnt_reach", one);
    apb(1'b1, IDX_PERIOD_LOW, 8'hff);
    apb(1'b1, IDX_PERIOD_HIGH, 8'hff);
    repeat (60) @(posedge sys_clk);
    apb(1'b1, IDX_MODE_CTRL, 8'h50);
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    bit_chk("cnt_run", rd != 32'h0);
    apb(1'b1, IDX_COUNT_HIGH, 8'h5a);
    rdchk("cnt_clr_lo", IDX_COUNT_LOW, 32'h0);
    rdchk("cnt_clr_hi", IDX_COUNT_HIGH, 32'h0);
  endtask : test_counter
  task automatic test_readable();
    logic [7:0] m [6] = '{8'hb0, 8'hf0, 8'h90, 8'hd0, 8'h80, 8'hc0};
    logic [5:0] e = 6'h38;
    logic [31:0] last;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, IDX_MODE_CTRL, m[i]);
      apb(1'b0, IDX_COUNT_LOW, 8'h00);
      rdchk("readable", IDX_STATUS, {31'h0, e[i]});
    end
    // Slow pwm clock, fast system clock: read until two reads agree
    do begin
      apb(1'b0, IDX_COUNT_LOW, 8'h00);
      last = rd;
      apb(1'b0, IDX_COUNT_LOW, 8'h00);
    end while (rd !== last);
    bit_chk("cnt_agree", rd != 32'h0);
    // Counter must not move while the clock enable is low
    clkEn <= 1'b0;
    repeat (200) @(posedge sys_clk);
    clkEn <= 1'b1;
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    bit_chk("frozen", rd - last <= 32'h2);
  endtask : test_readable
  task automatic test_deadtime();
    apb(1'b1, IDX_DUTY_LOW, 8'h34);
    apb(1'b1, IDX_DUTY_HIGH, 8'h12);
    apb(1'b1, IDX_MODE_CTRL, 8'h03);
    repeat (2) @(posedge sys_clk);
    check("dead_time", {16'h0, pwmOut.deadTime}, 32'h1234);
    check("ch5_out", {31'h0, pwmOut.ch5Out}, 32'h0);
    apb(1'b1, IDX_MODE_CTRL, 8'h02);
    @(posedge sys_clk);
    check("dead_off", {16'h0, pwmOut.deadTime}, 32'h0);
  endtask : test_deadtime
  task automatic test_divider();
    int n;
    int x;
    apb(1'b1, IDX_MODE_CTRL, 8'h05);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_DIV_CTRL, c[7:0]);
      n = 0;
      x = (c == 7) ? 512 : (512 >> c);
      repeat (2048) begin
        @(negedge sys_clk);
        if (pwmOut.ch4Tick === 1'b1) n++;
      end
      bit_chk("div_ticks", n >= x - 1 && n <= x + 1);
    end
  endtask : test_divider
  task automatic hold_chk(input int t, input logic [1:0] v);
    repeat (t) @(posedge sys_clk);
    check("ev4", {30'h0, pwmOut.ch4Event}, {30'h0, v});
    check("ev5", {30'h0, pwmOut.ch5Event}, {30'h0, v});
  endtask : hold_chk
  task automatic test_events();
    int w;
    logic quiet;
    for (int c = 0; c < 4; c++) begin
      w = 2 << c;
      apb(1'b1, IDX_SAMPLE_CTRL, {2'b00, c[1:0], 2'b00, c[1:0]});
      evtLevel <= 2'b11;
      hold_chk((w + 4) * 4 + 6, 2'b11);
      evtLevel <= 2'b00;
      hold_chk((w + 4) * 4 + 6, 2'b00);
      if (c > 0) begin
        quiet = 1'b1;
        evtLevel <= 2'b11;
        repeat (w * 2) @(posedge sys_clk);
        evtLevel <= 2'b00;
        repeat ((w + 4) * 4) begin
          @(posedge sys_clk);
          quiet = quiet & (pwmOut.ch4Event === 2'b00);
        end
        bit_chk("glitch", quiet);
      end
    end
    // Low-speed source: two slow ticks beat the sixteen-tick window
    apb(1'b1, IDX_MODE_CTRL, 8'h01);
    evtLevel <= 2'b11;
    hold_chk(56, 2'b11);
  endtask : test_events
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    evtLevel = 2'b00;
    clkEn = 1'b1;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    test_reset();
    test_reserved();
    test_counter();
    test_readable();
    test_deadtime();
    test_divider();
    test_events();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : testbench
bind pts_pwm_regs pts_chk pts_chk_i (.sys_clk(sys_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pwmOut(pwmOut));
`default_nettype wire
